// File: pkg/nvpc_cfg.svh
`ifndef NVPC_CFG_SVH
`define NVPC_CFG_SVH
// ****************************************
// Register map (word index, byte = 4*index)
// ****************************************
`define NVPC_EE_CTL_IDX 6'h1b
`define NVPC_OTP_CTL_IDX 6'h1c
`define NVPC_STATUS_IDX 6'h1f
// ****************************************
// Field positions
// ****************************************
`define NVPC_PUMP_BIT 6
`define NVPC_ERASE_HI 4
`define NVPC_ERASE_LO 3
`define NVPC_CAP_BIT 2
`define NVPC_RC_BIT 1
`define NVPC_PWR_BIT 0
`define NVPC_OCAP_BIT 1
`define NVPC_OPWR_BIT 0
`define NVPC_CTL_RESET 8'h00
// ****************************************
// Array map
// ****************************************
`define NVPC_EE_BASE 14'h0300
`define NVPC_EE_SIZE 240
`define NVPC_OTP_BASE 14'h1000
`define NVPC_OTP_SIZE 8128
`define NVPC_EE_ERASED 8'hff
`define NVPC_OTP_ERASED 8'h00
// ****************************************
// Timing
// ****************************************
`define NVPC_CLK_MHZ 25
`define NVPC_PULSE_US 10000
`define NVPC_RC_SETTLE_US 10
`define NVPC_RC_DIV 8
`endif

// File: pkg/nvpc_pkg.sv
package nvpc_pkg;
    // Erase select decode, order matches the two-bit field
    typedef enum logic [1:0] {
        ER_PROGRAM,
        ER_BYTE,
        ER_BLOCK,
        ER_BULK
    } nvpc_erase_t;
    // Program pulse sequencing
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_PULSE,
        ST_DONE
    } nvpc_state_t;
endpackage

// File: hdl/nvpc_tick.sv
`timescale 1ns/100ps
`include "nvpc_cfg.svh"
module nvpc_tick (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Source select
    input wire logic rc_sel,
    // Timing outputs
    output logic tick,
    output logic rc_ready
);
    import nvpc_pkg::*;
    localparam int SETTLE = `NVPC_RC_SETTLE_US * `NVPC_CLK_MHZ;
    logic [3:0] div_q;
    logic [11:0] settle_q;
    logic div_wrap;
    // Divider stands in for the slow RC oscillator
    assign div_wrap = (div_q == 4'(`NVPC_RC_DIV - 1));
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            div_q <= 4'h0;
            tick <= 1'b0;
        end else begin
            div_q <= div_wrap ? 4'h0 : div_q + 4'h1;
            tick <= rc_sel ? div_wrap : 1'b1;
        end
    end
    // Ready only after the oscillator settle time
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            settle_q <= 12'h000;
            rc_ready <= 1'b0;
        end else if (!rc_sel) begin
            settle_q <= 12'h000;
            rc_ready <= 1'b0;
        end else if (settle_q != 12'(SETTLE)) begin
            settle_q <= settle_q + 12'h001;
        end else begin
            rc_ready <= 1'b1;
        end
    end
endmodule

// File: hdl/nvpc_top.sv
// What this block does
// - Erasable control: pump bit6, bit5 zero, erase bits4-3, capture2, osc1, power0.
// - Pump bit set runs the charge pump; clear stops it.
// - Programming voltage reaches the erasable array only with program power set.
// - Erase field: 00 program, 01 byte, 10 block, 11 bulk.
// - Both erase bits are read/write and cleared by reset.
// - Byte erase clears only the latched address.
// - Block erase clears the whole 64-byte block holding the latched address.
// - Bulk erase clears all 240 bytes.
// - Capture set latches writes and blocks reads; clear gives normal reads.
// - Oscillator bit picks RC timing, otherwise CPU clock.
// - Power accepted only with capture already set; cleared when capture clears.
// - One write never sets both capture and power.
// - One-time control: bit1 capture, bit0 program power.
// - One-time capture latches writes and blocks reads.
// - One-time power settable only with capture; clears with capture.
// - One-time capture and power never set by one write.
// - Unprogrammed one-time locations read zero.
`timescale 1ns/100ps
`include "nvpc_cfg.svh"
module nvpc_top #(
    parameter int PULSE_CYCLES = `NVPC_PULSE_US * `NVPC_CLK_MHZ
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic ARST_N,
    // Wishbone slave
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    // Array access port
    input wire logic ARR_REQ,
    input wire logic ARR_WE,
    input wire logic [13:0] ARR_ADDR,
    input wire logic [7:0] ARR_WDATA,
    output logic [7:0] ARR_RDATA,
    output logic ARR_ACK,
    // Programming supply
    input wire logic OTP_VPP_OK,
    output logic PUMP_ON,
    output logic EE_VPP_ON,
    output logic OTP_PWR_ON,
    output logic EE_CLK_SRC
);
    import nvpc_pkg::*;
    // ****************************************
    // Declarations
    // ****************************************
    logic wb_go, wb_wr, ee_wr, otp_wr;
    logic [5:0] wb_idx;
    logic [7:0] wd, rd_mux, ee_ctl, otp_ctl, stat;
    logic pump_q, pump_d, cap_q, cap_d, pwr_q, pwr_d, rc_q, rc_d;
    logic [1:0] erase_q, erase_d;
    logic ocap_q, ocap_d, opwr_q, opwr_d;
    logic tick, rc_ready;
    logic arr_go, ee_hit, otp_hit;
    logic [7:0] ee_off, arr_rd;
    logic [12:0] otp_off;
    logic ee_lat_q, ee_cap_wr;
    logic [7:0] ee_a_q, ee_dat_q;
    logic otp_lat_q, otp_cap_wr;
    logic [12:0] otp_a_q;
    logic [7:0] otp_dat_q;
    nvpc_state_t ee_st_q;
    logic [19:0] ee_cnt_q, otp_cnt_q;
    logic ee_live, ee_commit, otp_live, otp_commit, otp_done_q;
    nvpc_erase_t mode;
    logic [7:0] ee_mem [0:`NVPC_EE_SIZE-1];
    logic [7:0] otp_mem [0:`NVPC_OTP_SIZE-1];
    localparam logic [19:0] PULSE_LAST = 20'(PULSE_CYCLES - 1);

    // Range check shared by both array windows
    function automatic logic in_win(input logic [13:0] a,
        input logic [13:0] base, input int size);
        in_win = (a >= base) && ({18'h0, a} < {18'h0, base} + 32'(size));
    endfunction

    // ****************************************
    // Wishbone register access
    // ****************************************
    // Writes land on the ack edge, as the master samples there
    assign wb_go = WB_CYC_I && WB_STB_I;
    assign wb_wr = wb_go && WB_ACK_O && WB_WE_I && WB_SEL_I[0];
    assign wb_idx = WB_ADR_I[7:2];
    assign wd = WB_DAT_I[7:0];
    assign ee_wr = wb_wr && (wb_idx == `NVPC_EE_CTL_IDX);
    assign otp_wr = wb_wr && (wb_idx == `NVPC_OTP_CTL_IDX);

    // Read views; unused bits read zero
    assign ee_ctl = {1'b0, pump_q, 1'b0, erase_q, cap_q, rc_q, pwr_q};
    assign otp_ctl = {6'h00, ocap_q, opwr_q};
    assign stat = {5'h00, otp_done_q, rc_ready, ee_st_q == ST_DONE};
    assign rd_mux = (wb_idx == `NVPC_EE_CTL_IDX) ? ee_ctl :
                    (wb_idx == `NVPC_OTP_CTL_IDX) ? otp_ctl :
                    (wb_idx == `NVPC_STATUS_IDX) ? stat : 8'h00;

    // Next values of the erasable control bits
    assign pump_d = ee_wr ? wd[`NVPC_PUMP_BIT] : pump_q;
    assign erase_d = ee_wr ? wd[`NVPC_ERASE_HI:`NVPC_ERASE_LO] : erase_q;
    assign cap_d = ee_wr ? wd[`NVPC_CAP_BIT] : cap_q;
    assign rc_d = ee_wr ? wd[`NVPC_RC_BIT] : rc_q;
    // Power needs capture already set, so a combined write cannot set it
    assign pwr_d = (ee_wr ? wd[`NVPC_PWR_BIT] & cap_q : pwr_q) & cap_d;

    // Next values of the one-time control bits
    assign ocap_d = otp_wr ? wd[`NVPC_OCAP_BIT] : ocap_q;
    assign opwr_d = (otp_wr ? wd[`NVPC_OPWR_BIT] & ocap_q : opwr_q) & ocap_d;

    // Bus answer: one cycle after the request, dropped the next cycle
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= 32'h0000_0000;
        end else begin
            WB_ACK_O <= wb_go && !WB_ACK_O;
            WB_DAT_O <= {24'h00_0000, rd_mux};
        end
    end

    // Control registers; reset clears all of them
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            {pump_q, erase_q, cap_q, rc_q, pwr_q} <= 6'h00;
            {ocap_q, opwr_q} <= 2'h0;
        end else begin
            {pump_q, erase_q, cap_q, rc_q, pwr_q} <=
                {pump_d, erase_d, cap_d, rc_d, pwr_d};
            {ocap_q, opwr_q} <= {ocap_d, opwr_d};
        end
    end

    // Supply outputs follow the next control state so they stay aligned
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            PUMP_ON <= 1'b0;
            EE_VPP_ON <= 1'b0;
            OTP_PWR_ON <= 1'b0;
            EE_CLK_SRC <= 1'b0;
        end else begin
            PUMP_ON <= pump_d;
            EE_VPP_ON <= pump_d && pwr_d;
            OTP_PWR_ON <= opwr_d && OTP_VPP_OK;
            EE_CLK_SRC <= rc_d;
        end
    end

    // ****************************************
    // Timing source
    // ****************************************
    nvpc_tick u_tick (
        .clk(CLK),
        .arst_n(ARST_N),
        .rc_sel(rc_q),
        .tick(tick),
        .rc_ready(rc_ready)
    );

    // ****************************************
    // Array port
    // ****************************************
    assign arr_go = ARR_REQ && ARR_ACK;
    assign ee_hit = in_win(ARR_ADDR, `NVPC_EE_BASE, `NVPC_EE_SIZE);
    assign otp_hit = in_win(ARR_ADDR, `NVPC_OTP_BASE, `NVPC_OTP_SIZE);
    assign ee_off = 8'(ARR_ADDR - `NVPC_EE_BASE);
    assign otp_off = 13'(ARR_ADDR - `NVPC_OTP_BASE);
    assign ee_cap_wr = arr_go && ARR_WE && ee_hit && cap_q;
    assign otp_cap_wr = arr_go && ARR_WE && otp_hit && ocap_q;
    // Captured arrays give no data
    assign arr_rd = ee_hit ? (cap_q ? 8'h00 : ee_mem[ee_off]) :
                    otp_hit ? (ocap_q ? 8'h00 : otp_mem[otp_off]) :
                    8'h00;

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ARR_ACK <= 1'b0;
            ARR_RDATA <= 8'h00;
        end else begin
            ARR_ACK <= ARR_REQ && !ARR_ACK;
            ARR_RDATA <= arr_rd;
        end
    end

    // Address and data capture; dropping capture forgets the target
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ee_lat_q <= 1'b0;
            ee_a_q <= 8'h00;
            ee_dat_q <= 8'h00;
        end else if (!cap_q) begin
            ee_lat_q <= 1'b0;
        end else if (ee_cap_wr) begin
            ee_lat_q <= 1'b1;
            ee_a_q <= ee_off;
            ee_dat_q <= ARR_WDATA;
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            otp_lat_q <= 1'b0;
            otp_a_q <= 13'h0000;
            otp_dat_q <= 8'h00;
        end else if (!ocap_q) begin
            otp_lat_q <= 1'b0;
        end else if (otp_cap_wr) begin
            otp_lat_q <= 1'b1;
            otp_a_q <= otp_off;
            otp_dat_q <= ARR_WDATA;
        end
    end

    // ****************************************
    // Erasable program pulse
    // ****************************************
    // Pulse runs only with pump and power both on; losing either aborts
    assign ee_live = pump_q && pwr_q && ee_lat_q;
    assign ee_commit = (ee_st_q == ST_PULSE) && ee_live && tick &&
                       (ee_cnt_q == PULSE_LAST);
    assign mode = nvpc_erase_t'(erase_q);

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ee_st_q <= ST_IDLE;
            ee_cnt_q <= 20'h00000;
        end else begin
            case (ee_st_q)
                ST_IDLE: begin
                    ee_cnt_q <= 20'h00000;
                    if (ee_live) begin
                        ee_st_q <= ST_PULSE;
                    end
                end
                ST_PULSE: begin
                    if (!ee_live) begin
                        ee_st_q <= ST_IDLE;
                    end else if (ee_commit) begin
                        ee_st_q <= ST_DONE;
                    end else if (tick) begin
                        ee_cnt_q <= ee_cnt_q + 20'h00001;
                    end
                end
                ST_DONE: begin
                    if (!pwr_q) begin
                        ee_st_q <= ST_IDLE;
                    end
                end
                default: begin
                    ee_st_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Array cells are not reset; erased state is the start state
    initial begin
        for (int i = 0; i < `NVPC_EE_SIZE; i++) begin
            ee_mem[i] = `NVPC_EE_ERASED;
        end
        for (int i = 0; i < `NVPC_OTP_SIZE; i++) begin
            otp_mem[i] = `NVPC_OTP_ERASED;
        end
    end

    // Erasable cell updates by mode
    always @(posedge CLK) begin
        if (ee_commit) begin
            for (int i = 0; i < `NVPC_EE_SIZE; i++) begin
                if (mode == ER_BULK) begin
                    ee_mem[i] <= `NVPC_EE_ERASED;
                end else if (mode == ER_BLOCK && 2'(i >> 6) == ee_a_q[7:6]) begin
                    ee_mem[i] <= `NVPC_EE_ERASED;
                end
            end
            if (mode == ER_PROGRAM) begin
                ee_mem[ee_a_q] <= ee_dat_q;
            end else if (mode == ER_BYTE) begin
                ee_mem[ee_a_q] <= `NVPC_EE_ERASED;
            end
        end
    end

    // ****************************************
    // One-time program pulse
    // ****************************************
    // Without the external supply nothing is programmed
    assign otp_live = opwr_q && OTP_VPP_OK && otp_lat_q && !otp_done_q;
    assign otp_commit = otp_live && (otp_cnt_q == PULSE_LAST);

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            otp_cnt_q <= 20'h00000;
            otp_done_q <= 1'b0;
        end else if (!opwr_q) begin
            otp_cnt_q <= 20'h00000;
            otp_done_q <= 1'b0;
        end else if (otp_commit) begin
            otp_done_q <= 1'b1;
        end else if (otp_live) begin
            otp_cnt_q <= otp_cnt_q + 20'h00001;
        end
    end

    // Programming can only raise bits
    always @(posedge CLK) begin
        if (otp_commit) begin
            otp_mem[otp_a_q] <= otp_mem[otp_a_q] | otp_dat_q;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!ARST_N);

    sequence s_ee_write;
        ee_wr;
    endsequence
    sequence s_pump_follows;
        ##1 PUMP_ON == $past(wd[`NVPC_PUMP_BIT]);
    endsequence

    chk_pump_follow_write: assert property (s_ee_write |-> s_pump_follows)
        else $error("pump output did not follow control write");
    chk_vpp_needs_power: assert property (EE_VPP_ON |-> pwr_q && pump_q)
        else $error("programming voltage without power bit");
    chk_erase_readback: assert property (ee_wr |=> erase_q == $past(wd[4:3]))
        else $error("erase select not stored");
    chk_power_needs_capture: assert property ($rose(pwr_q) |-> $past(cap_q))
        else $error("power set without prior capture");
    chk_combined_write_refused: assert property (
        ee_wr && !cap_q && wd[`NVPC_PWR_BIT] |=> !pwr_q)
        else $error("combined write set power");
    chk_power_drops: assert property (!cap_q |-> !pwr_q)
        else $error("power held without capture");
    chk_otp_power_rule: assert property ($rose(opwr_q) |-> $past(ocap_q) && ocap_q)
        else $error("one-time power set without capture");
    chk_otp_combined: assert property (
        otp_wr && !ocap_q |=> !opwr_q)
        else $error("one-time combined write set power");
    chk_capture_no_read: assert property (
        ARR_REQ && !ARR_ACK && !ARR_WE && ee_hit && cap_q ##1 ARR_ACK |-> ARR_RDATA == 8'h00)
        else $error("captured array returned data");
    chk_clock_source: assert property (ee_wr |=> EE_CLK_SRC == $past(wd[`NVPC_RC_BIT]))
        else $error("clock source mismatch");
    chk_bulk_erase: assert property (ee_commit && mode == ER_BULK |=>
        ee_mem[0] == `NVPC_EE_ERASED && ee_mem[`NVPC_EE_SIZE-1] == `NVPC_EE_ERASED)
        else $error("bulk erase missed cells");
    chk_byte_erase: assert property (ee_commit && mode == ER_BYTE |=>
        ee_mem[ee_a_q] == `NVPC_EE_ERASED)
        else $error("byte erase missed target");
endmodule

// File: verification/nvpc_top_test.sv
`timescale 1ns/100ps
`include "nvpc_cfg.svh"
module nvpc_top_test;
    import nvpc_pkg::*;
    // ****************************************
    // Settings and connections
    // ****************************************
    localparam int PULSE = 4; // Short pulse keeps the run brief
    localparam int MAX_CYCLES = 20000;
    localparam logic [7:0] A_EE = {`NVPC_EE_CTL_IDX, 2'b00};
    localparam logic [7:0] A_OTP = {`NVPC_OTP_CTL_IDX, 2'b00};
    localparam logic [7:0] A_ST = {`NVPC_STATUS_IDX, 2'b00};
    localparam logic [13:0] OTP_A = `NVPC_OTP_BASE + 14'h0005;
    localparam logic [13:0] PA [4] = '{14'h0300, 14'h0301, 14'h0340, 14'h03ef};
    localparam logic [7:0] PD [4] = '{8'h5a, 8'h33, 8'h11, 8'h22};
    logic clk = 1'b0;
    logic arst_n, cyc, stb, we, ack, arr_req, arr_we, arr_ack, vpp_ok;
    logic pump_on, ee_vpp_on, otp_pwr_on, ee_clk_src;
    logic [7:0] adr, arr_wdata, arr_rdata;
    logic [3:0] sel;
    logic [31:0] wdat, rdat;
    logic [13:0] arr_addr;
    int failures = 0;
    int n_checks = 0;
    int cycles = 0;
    int i;

    nvpc_top #(.PULSE_CYCLES(PULSE)) dut_u (
        .CLK(clk), .ARST_N(arst_n),
        .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
        .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
        .ARR_REQ(arr_req), .ARR_WE(arr_we), .ARR_ADDR(arr_addr), .ARR_WDATA(arr_wdata),
        .ARR_RDATA(arr_rdata), .ARR_ACK(arr_ack),
        .OTP_VPP_OK(vpp_ok), .PUMP_ON(pump_on), .EE_VPP_ON(ee_vpp_on),
        .OTP_PWR_ON(otp_pwr_on), .EE_CLK_SRC(ee_clk_src)
    );

    // 25 MHz clock and a cycle ceiling against hangs
    always #20 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == MAX_CYCLES) begin
            failures++;
            end_sim();
        end
    end

    // ****************************************
    // Compare tasks
    // ****************************************
    task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected register at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected array byte at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Caller lets the edge's updates land before calling
    task automatic check_pin(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected pin at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // ****************************************
    // Bus tasks
    // ****************************************
    // Request held until ack is sampled high, released after that edge only
    task automatic wb_access(input logic w, input logic [7:0] a, input logic [7:0] d,
                             output logic [31:0] q);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'h1;
        wdat <= {24'h000000, d};
        do @(posedge clk); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic wb_wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        wb_access(1'b1, a, d, q);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        wb_access(1'b0, a, 8'h00, q);
        check_reg(q, exp);
    endtask
    task automatic arr_access(input logic w, input logic [13:0] a, input logic [7:0] d,
                              output logic [7:0] q);
        @(posedge clk);
        arr_req <= 1'b1;
        arr_we <= w;
        arr_addr <= a;
        arr_wdata <= d;
        do @(posedge clk); while (arr_ack !== 1'b1);
        q = arr_rdata;
        arr_req <= 1'b0;
        arr_we <= 1'b0;
    endtask
    task automatic arr_wr(input logic [13:0] a, input logic [7:0] d);
        logic [7:0] q;
        arr_access(1'b1, a, d, q);
    endtask
    task automatic arr_chk(input logic [13:0] a, input logic [7:0] exp);
        logic [7:0] q;
        arr_access(1'b0, a, 8'h00, q);
        check_byte(q, exp);
    endtask
    // Polls status; bounded so a stuck pulse shows up as a mismatch
    task automatic wait_status(input int b);
        logic [31:0] q;
        for (int k = 0; k < 120; k++) begin
            wb_access(1'b0, A_ST, 8'h00, q);
            if (q[b] === 1'b1) break;
        end
        check_pin(q[b], 1'b1);
    endtask
    // Capture, latch the write, pump with power, pulse, then idle
    task automatic ee_op(input logic [1:0] m, input logic [13:0] a, input logic [7:0] d);
        wb_wr(A_EE, {3'b000, m, 3'b100});
        arr_wr(a, d);
        wb_wr(A_EE, {3'b010, m, 3'b100});
        wb_wr(A_EE, {3'b010, m, 3'b101});
        wait_status(0);
        wb_wr(A_EE, 8'h00);
    endtask
    task automatic end_sim();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        arst_n = 1'b0;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        sel = 4'h0;
        wdat = 32'h0;
        arr_req = 1'b0;
        arr_we = 1'b0;
        arr_addr = 14'h0;
        arr_wdata = 8'h00;
        vpp_ok = 1'b0;
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        rd_chk(A_EE, 32'h0);
        rd_chk(A_OTP, 32'h0);
        wb_wr(A_EE, 8'hff);
        rd_chk(A_EE, 32'h5e);
        #1;
        check_pin(pump_on, 1'b1);
        check_pin(ee_clk_src, 1'b1);
        check_pin(ee_vpp_on, 1'b0);
        for (i = 0; i < 4; i++) begin
            wb_wr(A_EE, 8'(i << 3));
            rd_chk(A_EE, 32'(i << 3));
        end
        #1;
        check_pin(pump_on, 1'b0);
        check_pin(ee_clk_src, 1'b0);
        wb_wr(A_EE, 8'h04);
        wb_wr(A_EE, 8'h05);
        rd_chk(A_EE, 32'h05);
        #1;
        check_pin(ee_vpp_on, 1'b0);
        wb_wr(A_EE, 8'h45);
        #1;
        check_pin(ee_vpp_on, 1'b1);
        wb_wr(A_EE, 8'h41);
        rd_chk(A_EE, 32'h40);
        #1;
        check_pin(ee_vpp_on, 1'b0);
        wb_wr(A_EE, 8'h00);
        arr_wr(14'h0302, 8'h00);
        arr_chk(14'h0302, `NVPC_EE_ERASED);
        for (i = 0; i < 4; i++) begin
            ee_op(ER_PROGRAM, PA[i], PD[i]);
            arr_chk(PA[i], PD[i]);
        end
        wb_wr(A_EE, 8'h04);
        arr_chk(14'h0300, 8'h00);
        ee_op(ER_BYTE, 14'h0301, 8'h00);
        arr_chk(14'h0301, `NVPC_EE_ERASED);
        arr_chk(14'h0300, 8'h5a);
        ee_op(ER_BLOCK, 14'h037f, 8'h00);
        arr_chk(14'h0340, `NVPC_EE_ERASED);
        arr_chk(14'h0300, 8'h5a);
        arr_chk(14'h03ef, 8'h22);
        ee_op(ER_BULK, 14'h0300, 8'h00);
        arr_chk(14'h0300, `NVPC_EE_ERASED);
        arr_chk(14'h03ef, `NVPC_EE_ERASED);
        // One-time array: erased reads, refused power, one byte programmed
        arr_chk(OTP_A, `NVPC_OTP_ERASED);
        wb_wr(A_OTP, 8'h01);
        rd_chk(A_OTP, 32'h0);
        vpp_ok <= 1'b1;
        wb_wr(A_OTP, 8'h03);
        rd_chk(A_OTP, 32'h02);
        arr_wr(OTP_A, 8'ha5);
        arr_chk(OTP_A, 8'h00);
        wb_wr(A_OTP, 8'h03);
        rd_chk(A_OTP, 32'h03);
        #1;
        check_pin(otp_pwr_on, 1'b1);
        wait_status(2);
        wb_wr(A_OTP, 8'h01);
        rd_chk(A_OTP, 32'h0);
        #1;
        check_pin(otp_pwr_on, 1'b0);
        arr_chk(OTP_A, 8'ha5);
        // Slow-clock programming: the test waits for the RC source to settle before the pulse, though the pulse does not depend on rc_ready
        wb_wr(A_EE, 8'h02);
        rd_chk(A_ST, 32'h0);
        wait_status(1);
        wb_wr(A_EE, 8'h06);
        arr_wr(14'h0310, 8'h77);
        wb_wr(A_EE, 8'h46);
        wb_wr(A_EE, 8'h47);
        #1;
        check_pin(ee_clk_src, 1'b1);
        wait_status(0);
        wb_wr(A_EE, 8'h00);
        arr_chk(14'h0310, 8'h77);
        // Unmapped word is acked, reads zero, ignores writes
        wb_wr(8'h00, 8'hff);
        rd_chk(8'h00, 32'h0);
        // Reset in mid-run clears live controls
        wb_wr(A_EE, 8'h44);
        wb_wr(A_EE, 8'h45);
        wb_wr(A_OTP, 8'h02);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        check_pin(ee_vpp_on, 1'b0);
        check_pin(pump_on, 1'b0);
        @(posedge clk);
        arst_n <= 1'b1;
        rd_chk(A_EE, 32'h0);
        rd_chk(A_OTP, 32'h0);
        end_sim();
    end
endmodule
